// file: core/cq_sideband_pkg.sv
// Purpose: Shared constants for the request sideband framer
// Assumes: 256-bit maximum data path, 85-bit sideband word
// Notes: Lane mask function serves both the enables and the parity
package cq_sideband_pkg;

	// Data path geometry
	localparam int DATA_WIDTH = 256;
	localparam int LANE_COUNT = 32;
	localparam int DWORD_COUNT = 8;
	localparam int SIDEBAND_WIDTH = 85;

	// Sideband field positions
	localparam int SB_HEAD_LSB = 0;
	localparam int SB_TAIL_LSB = 4;
	localparam int SB_BYTE_EN_LSB = 8;
	localparam int SB_SOP_BIT = 40;
	localparam int SB_ABORT_BIT = 41;
	localparam int SB_HINT_BIT = 42;
	localparam int SB_HINT_TYPE_LSB = 43;
	localparam int SB_STEER_LSB = 45;
	localparam int SB_PARITY_LSB = 53;

	// Data path width codes held in the control register
	localparam logic [1:0] WIDTH_64 = 2'h0;
	localparam logic [1:0] WIDTH_128 = 2'h1;
	localparam logic [1:0] WIDTH_256 = 2'h2;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] ERROR_OFFSET = 12'h008;

	// Control register fields
	localparam int CTRL_WIDTH_LSB = 0;
	localparam int CTRL_ENDPOINT_BIT = 2;
	localparam logic [1:0] CTRL_WIDTH_RESET = 2'h2;
	localparam logic CTRL_ENDPOINT_RESET = 1'b1;

	// Status register fields
	localparam int STATUS_PKT_LSB = 0;
	localparam int STATUS_ABORT_LSB = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Error register fields
	localparam int ERROR_STICKY_BIT = 0;

	// Byte lanes live for a width code
	function automatic logic [31:0] lane_mask(input logic [1:0] width_code);
		case (width_code)
			WIDTH_64: lane_mask = 32'h000000FF;
			WIDTH_128: lane_mask = 32'h0000FFFF;
			default: lane_mask = 32'hFFFFFFFF;
		endcase
	endfunction

endpackage

// file: core/payload_byte_mask.sv
// Purpose: Per-byte payload enables for one beat
// Assumes: Source marks payload dwords; header masks valid on the beat
// Notes: Purely combinational leaf
`timescale 1ns/1ps
module payload_byte_mask (
	input wire logic [7:0] payload_dwords,
	input wire logic first_payload_beat,
	input wire logic last_payload_beat,
	input wire logic [3:0] head_mask,
	input wire logic [3:0] tail_mask,
	input wire logic force_all_ones,
	input wire logic zero_length,
	input wire logic [31:0] lanes,
	output logic [31:0] byte_enable
);

	// Expand dwords, trim the first and last payload dword
	always_comb begin
		logic found;
		logic [31:0] be;
		found = 1'b0;
		be = '0;
		for (int i = 0; i < cq_sideband_pkg::DWORD_COUNT; i++) begin
			if (payload_dwords[i]) begin
				be[i*4 +: 4] = 4'hF;
			end
		end
		if (!force_all_ones) begin
			for (int i = 0; i < cq_sideband_pkg::DWORD_COUNT; i++) begin
				if (payload_dwords[i] && !found && first_payload_beat) begin
					be[i*4 +: 4] = be[i*4 +: 4] & head_mask;
				end
				if (payload_dwords[i]) begin
					found = 1'b1;
				end
			end
			found = 1'b0;
			// Tail mask is zero for single-dword payloads
			for (int i = cq_sideband_pkg::DWORD_COUNT - 1; i >= 0; i--) begin
				if (payload_dwords[i] && !found && last_payload_beat && tail_mask != 4'h0) begin
					be[i*4 +: 4] = be[i*4 +: 4] & tail_mask;
				end
				if (payload_dwords[i]) begin
					found = 1'b1;
				end
			end
		end
		if (zero_length) begin
			be = '0;
		end
		byte_enable = be & lanes;
	end

endmodule

// file: core/byte_odd_parity.sv
// Purpose: Odd parity for each byte of the data bus
// Assumes: Unused lanes masked by the caller's lane mask
// Notes: Purely combinational leaf
`timescale 1ns/1ps
module byte_odd_parity (
	input wire logic [255:0] data,
	input wire logic [31:0] lanes,
	output logic [31:0] parity
);

	// Parity bit makes each byte plus bit odd
	always_comb begin
		parity = '0;
		for (int i = 0; i < cq_sideband_pkg::LANE_COUNT; i++) begin
			parity[i] = ~^data[i*8 +: 8] & lanes[i];
		end
	end

endmodule

// file: core/completer_request_sideband.sv
// Purpose: Frames request beats with their 85-bit sideband word
// Assumes: Internal source on pclk; APB slave for control and status
// Notes: Output stage plus one skid entry keeps ready registered
//
// Functional notes
// - Head dword byte mask in bits 3:0
// - Tail dword byte mask in bits 7:4
// - Atomics and payload messages force masks ones
// - Masks valid only on first valid beat
// - Bits 39:8 mark payload bytes, never descriptor
// - Enables contiguous beyond two dwords of payload
// - Zero-length write drives all enables low
// - Upper enables zero on narrow data paths
// - Bit 40 marks the first beat
// - Bit 41 flags payload read error, last beat
// - Abort never without payload, only on last
// - Endpoint reports payload errors as AER event
// - Bit 42 flags a hint, first beat
// - Bits 44:43 carry hint type, first beat
// - Bits 52:45 carry steering value, first beat
// - Bits 84:53 odd parity per data byte
// - Unused upper parity bits held at zero
// - Sideband 85 bits, meaningful while valid
// - Transfer on valid and ready; hold when stalled
`timescale 1ns/1ps
module completer_request_sideband (
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Internal request source
	input wire logic source_valid,
	output logic source_ready,
	input wire logic [255:0] source_data,
	input wire logic source_last,
	input wire logic [7:0] source_payload_dwords,
	input wire logic source_first_payload_beat,
	input wire logic source_last_payload_beat,
	input wire logic source_has_payload,
	input wire logic source_zero_length,
	input wire logic source_force_masks,
	input wire logic source_fifo_error,
	input wire logic [3:0] head_dword_byte_mask,
	input wire logic [3:0] tail_dword_byte_mask,
	input wire logic source_hint_present,
	input wire logic [1:0] source_hint_type,
	input wire logic [7:0] hint_steering_value,
	// Request stream to user logic
	output logic request_valid,
	input wire logic request_ready,
	output logic [255:0] request_data_bus,
	output logic request_last_beat,
	output logic [84:0] request_sideband_bus,
	// Error report toward the link error logic
	output logic aer_payload_error
);

	typedef enum logic [1:0] {
		PKT_START = 2'b00,
		PKT_BODY = 2'b01
	} packet_state_type;

	// Control and status state
	logic [1:0] width_code;
	logic endpoint_mode;
	logic [15:0] pkt_count;
	logic [15:0] abort_count;
	logic error_sticky;
	logic [1:0] next_width_code;
	logic next_endpoint_mode;
	logic [15:0] next_pkt_count;
	logic [15:0] next_abort_count;
	logic next_error_sticky;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_aer_payload_error;

	// Packet tracking state
	packet_state_type pkt_state;
	packet_state_type next_pkt_state;
	logic err_seen;
	logic next_err_seen;
	logic has_payload;
	logic next_has_payload;

	// Output stage and skid entry
	logic skid_valid;
	logic [255:0] skid_data;
	logic skid_last;
	logic [84:0] skid_sideband;
	logic next_skid_valid;
	logic [255:0] next_skid_data;
	logic next_skid_last;
	logic [84:0] next_skid_sideband;
	logic next_request_valid;
	logic [255:0] next_request_data_bus;
	logic next_request_last_beat;
	logic [84:0] next_request_sideband_bus;
	logic next_source_ready;

	// Beat being framed
	logic accept;
	logic out_free;
	logic sop;
	logic [31:0] lanes;
	logic [255:0] beat_data;
	logic [31:0] beat_byte_en;
	logic [31:0] beat_parity;
	logic [84:0] beat_sideband;
	logic abort_now;
	logic out_fire;

	assign lanes = cq_sideband_pkg::lane_mask(width_code);
	assign accept = source_valid & source_ready;
	assign out_free = !request_valid | request_ready;
	assign out_fire = request_valid & request_ready;
	assign sop = pkt_state == PKT_START;

	// Narrow paths hold the unused data lanes at zero
	always_comb begin
		beat_data = source_data;
		for (int i = 0; i < cq_sideband_pkg::LANE_COUNT; i++) begin
			if (!lanes[i]) begin
				beat_data[i*8 +: 8] = 8'h00;
			end
		end
	end

	payload_byte_mask u_byte_mask (
		.payload_dwords(source_payload_dwords),
		.first_payload_beat(source_first_payload_beat),
		.last_payload_beat(source_last_payload_beat),
		.head_mask(head_dword_byte_mask),
		.tail_mask(tail_dword_byte_mask),
		.force_all_ones(source_force_masks),
		.zero_length(source_zero_length),
		.lanes(lanes),
		.byte_enable(beat_byte_en)
	);

	byte_odd_parity u_parity (
		.data(beat_data),
		.lanes(lanes),
		.parity(beat_parity)
	);

	// Abort only on the last beat of a packet that carries payload
	assign abort_now = source_last & (err_seen | source_fifo_error) & (has_payload
		| (sop & source_has_payload));

	// Assemble the sideband word for this beat
	always_comb begin
		beat_sideband = '0;
		if (sop) begin
			if (source_force_masks) begin
				beat_sideband[cq_sideband_pkg::SB_HEAD_LSB +: 4] = 4'hF;
				beat_sideband[cq_sideband_pkg::SB_TAIL_LSB +: 4] = 4'hF;
			end else begin
				beat_sideband[cq_sideband_pkg::SB_HEAD_LSB +: 4] = head_dword_byte_mask;
				beat_sideband[cq_sideband_pkg::SB_TAIL_LSB +: 4] = tail_dword_byte_mask;
			end
			beat_sideband[cq_sideband_pkg::SB_SOP_BIT] = 1'b1;
			beat_sideband[cq_sideband_pkg::SB_HINT_BIT] = source_hint_present;
			if (source_hint_present) begin
				beat_sideband[cq_sideband_pkg::SB_HINT_TYPE_LSB +: 2] = source_hint_type;
				beat_sideband[cq_sideband_pkg::SB_STEER_LSB +: 8] = hint_steering_value;
			end
		end
		beat_sideband[cq_sideband_pkg::SB_BYTE_EN_LSB +: 32] = beat_byte_en;
		beat_sideband[cq_sideband_pkg::SB_ABORT_BIT] = abort_now;
		beat_sideband[cq_sideband_pkg::SB_PARITY_LSB +: 32] = beat_parity;
	end

	// Packet boundary and error accumulation on accepted beats
	always_comb begin
		next_pkt_state = pkt_state;
		next_err_seen = err_seen;
		next_has_payload = has_payload;
		if (accept) begin
			if (source_last) begin
				next_pkt_state = PKT_START;
				next_err_seen = 1'b0;
				next_has_payload = 1'b0;
			end else begin
				next_pkt_state = PKT_BODY;
				next_err_seen = err_seen | source_fifo_error;
				next_has_payload = has_payload | (sop & source_has_payload);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_state <= PKT_START;
			err_seen <= 1'b0;
			has_payload <= 1'b0;
		end else begin
			pkt_state <= next_pkt_state;
			err_seen <= next_err_seen;
			has_payload <= next_has_payload;
		end
	end

	// Output stage: load, drain skid, or hold while stalled
	always_comb begin
		next_request_valid = request_valid;
		next_request_data_bus = request_data_bus;
		next_request_last_beat = request_last_beat;
		next_request_sideband_bus = request_sideband_bus;
		next_skid_valid = skid_valid;
		next_skid_data = skid_data;
		next_skid_last = skid_last;
		next_skid_sideband = skid_sideband;
		if (skid_valid && out_free) begin
			next_request_valid = 1'b1;
			next_request_data_bus = skid_data;
			next_request_last_beat = skid_last;
			next_request_sideband_bus = skid_sideband;
			next_skid_valid = 1'b0;
		end else if (accept && out_free) begin
			next_request_valid = 1'b1;
			next_request_data_bus = beat_data;
			next_request_last_beat = source_last;
			next_request_sideband_bus = beat_sideband;
		end else if (accept) begin
			next_skid_valid = 1'b1;
			next_skid_data = beat_data;
			next_skid_last = source_last;
			next_skid_sideband = beat_sideband;
		end else if (request_ready) begin
			next_request_valid = 1'b0;
		end
		// Output word only changes when the slot is free
		if (!out_free) begin
			next_request_data_bus = request_data_bus;
			next_request_sideband_bus = request_sideband_bus;
			next_request_last_beat = request_last_beat;
		end
		next_source_ready = !next_skid_valid;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			request_valid <= 1'b0;
			request_data_bus <= '0;
			request_last_beat <= 1'b0;
			request_sideband_bus <= '0;
			skid_valid <= 1'b0;
			skid_data <= '0;
			skid_last <= 1'b0;
			skid_sideband <= '0;
			source_ready <= 1'b0;
		end else begin
			request_valid <= next_request_valid;
			request_data_bus <= next_request_data_bus;
			request_last_beat <= next_request_last_beat;
			request_sideband_bus <= next_request_sideband_bus;
			skid_valid <= next_skid_valid;
			skid_data <= next_skid_data;
			skid_last <= next_skid_last;
			skid_sideband <= next_skid_sideband;
			source_ready <= next_source_ready;
		end
	end

	// Registers, counters, error report and APB answers
	always_comb begin
		logic abort_out;
		abort_out = out_fire & request_sideband_bus[cq_sideband_pkg::SB_ABORT_BIT];
		next_width_code = width_code;
		next_endpoint_mode = endpoint_mode;
		next_pkt_count = pkt_count;
		next_abort_count = abort_count;
		next_error_sticky = error_sticky;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_pready = psel & !penable;
		next_aer_payload_error = abort_out & endpoint_mode;
		if (out_fire && request_last_beat) begin
			next_pkt_count = pkt_count + 16'h0001;
		end
		if (abort_out) begin
			next_abort_count = abort_count + 16'h0001;
		end
		// Setup phase: prepare read data and error answer
		if (psel && !penable) begin
			next_prdata = '0;
			case (paddr)
				cq_sideband_pkg::CTRL_OFFSET: begin
					next_prdata[cq_sideband_pkg::CTRL_WIDTH_LSB +: 2] = width_code;
					next_prdata[cq_sideband_pkg::CTRL_ENDPOINT_BIT] = endpoint_mode;
				end
				cq_sideband_pkg::STATUS_OFFSET: begin
					next_prdata[cq_sideband_pkg::STATUS_PKT_LSB +: 16] = pkt_count;
					next_prdata[cq_sideband_pkg::STATUS_ABORT_LSB +: 16] = abort_count;
				end
				cq_sideband_pkg::ERROR_OFFSET: begin
					next_prdata[cq_sideband_pkg::ERROR_STICKY_BIT] = error_sticky;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		// Access phase write; status counters are read-only
		if (psel && penable && pready && pwrite) begin
			if (paddr == cq_sideband_pkg::CTRL_OFFSET) begin
				next_width_code = pwdata[cq_sideband_pkg::CTRL_WIDTH_LSB +: 2];
				next_endpoint_mode = pwdata[cq_sideband_pkg::CTRL_ENDPOINT_BIT];
			end
			if (paddr == cq_sideband_pkg::ERROR_OFFSET
				&& pwdata[cq_sideband_pkg::ERROR_STICKY_BIT]) begin
				next_error_sticky = 1'b0;
			end
		end
		// A new abort beats a clear in the same cycle
		if (abort_out) begin
			next_error_sticky = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			width_code <= cq_sideband_pkg::CTRL_WIDTH_RESET;
			endpoint_mode <= cq_sideband_pkg::CTRL_ENDPOINT_RESET;
			pkt_count <= cq_sideband_pkg::COUNT_RESET;
			abort_count <= cq_sideband_pkg::COUNT_RESET;
			error_sticky <= 1'b0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			aer_payload_error <= 1'b0;
		end else begin
			width_code <= next_width_code;
			endpoint_mode <= next_endpoint_mode;
			pkt_count <= next_pkt_count;
			abort_count <= next_abort_count;
			error_sticky <= next_error_sticky;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			aer_payload_error <= next_aer_payload_error;
		end
	end

endmodule

// file: dv/cq_sideband_asserts.sv
// Purpose: Port checks for the request sideband framer
// Assumes: One clock, async active-low reset
// Notes: Bound after the module
`timescale 1ns/1ps
module cq_sideband_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic request_valid,
	input wire logic request_ready,
	input wire logic [255:0] request_data_bus,
	input wire logic request_last_beat,
	input wire logic [84:0] request_sideband_bus,
	input wire logic aer_payload_error
);
	logic [31:0] odd_par;
	logic [31:0] nz;
	logic at_start;
	logic next_at_start;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Odd parity and nonzero flag per byte
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			odd_par[i] = ~^request_data_bus[8*i+:8];
			nz[i] = |request_data_bus[8*i+:8];
		end
	end
	// Next transferred beat opens a packet
	always_comb begin
		next_at_start = at_start;
		if (request_valid && request_ready)
			next_at_start = request_last_beat;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			at_start <= 1'h1;
		else
			at_start <= next_at_start;
	end
	a_stall_hold: assert property (
		request_valid && !request_ready |=> request_valid && $stable(request_sideband_bus)
		&& $stable(request_data_bus) && $stable(request_last_beat)) else $error("stall broke");
	a_abort_last: assert property (
		request_valid && request_sideband_bus[41] |-> request_last_beat) else $error("abort");
	a_sop_order: assert property (
		request_valid |-> request_sideband_bus[40] == at_start) else $error("sop misplaced");
	a_first_only: assert property (
		request_valid && !request_sideband_bus[40] |-> request_sideband_bus[7:0] == 8'h00
		&& request_sideband_bus[52:42] == 11'h000) else $error("first fields late");
	a_parity_ok: assert property (
		request_valid |-> ((request_sideband_bus[84:53] ^ odd_par) & nz) == 32'h0
		&& (request_sideband_bus[84:53] & ~odd_par) == 32'h0) else $error("parity wrong");
	a_aer_cause: assert property (
		aer_payload_error |-> $past(request_valid) && $past(request_ready)
		&& $past(request_last_beat) && $past(request_sideband_bus[41])) else $error("aer");
	a_apb_answer: assert property (
		psel && !penable |=> pready) else $error("no apb answer");
	a_unmapped_err: assert property (
		psel && !penable && paddr > 12'h008 |=> pslverr) else $error("no slave error");
endmodule
bind completer_request_sideband cq_sideband_checker u_checker (.pclk, .presetn, .psel,
	.penable, .paddr, .pready, .pslverr, .request_valid, .request_ready, .request_data_bus,
	.request_last_beat, .request_sideband_bus, .aer_payload_error);

// file: dv/cq_user_sink.sv
// Purpose: User logic receiving request beats
// Assumes: Ready pattern chosen by the bench
// Notes: Drops aborted packets and counts only those
`timescale 1ns/1ps
module cq_user_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall_mode,
	input wire logic request_valid,
	output logic request_ready,
	input wire logic request_last_beat,
	input wire logic [84:0] request_sideband_bus,
	output logic [7:0] dropped
);
	logic [1:0] phase;
	// Ready every cycle, or one cycle in four when stalling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
			request_ready <= 1'h0;
			dropped <= 8'h00;
		end else begin
			phase <= phase + 2'h1;
			request_ready <= !stall_mode || phase == 2'h3;
			// Sideband only read on a transfer
			if (request_valid && request_ready && request_last_beat) begin
				if (request_sideband_bus[41])
					dropped <= dropped + 8'h01;
			end
		end
	end
endmodule

// file: dv/completer_request_sideband_tb.sv
// Purpose: Self-checking bench for the request sideband framer
// Assumes: Zero-wait APB slave; source driven by the bench
// Notes: Row table runs at each data path width
`timescale 1ns/1ps
module completer_request_sideband_tb;
	typedef struct {
		logic [7:0] pdw;
		logic [5:0] fl;
		logic [3:0] head;
		logic [3:0] tail;
		logic hint;
		logic [1:0] htype;
		logic [7:0] steer;
		logic [7:0] xmask;
		logic [31:0] xen;
	} row_type;
	row_type rows [7];
	row_type cur;
	row_type beat;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, stall_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ln, par;
	logic source_valid, source_ready, source_last;
	logic [255:0] source_data, d, dm, request_data_bus;
	logic request_valid, request_ready, request_last_beat, aer_payload_error;
	logic [84:0] request_sideband_bus, xsb;
	logic [7:0] dropped;
	int total_checks = 0;
	int miscompares = 0;
	int cycles = 0;
	int aer_seen = 0;

	completer_request_sideband DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .source_valid, .source_ready, .source_data, .source_last,
		.source_payload_dwords(cur.pdw), .source_first_payload_beat(cur.fl[5]),
		.source_last_payload_beat(cur.fl[4]), .source_has_payload(cur.fl[3]),
		.source_zero_length(cur.fl[2]), .source_force_masks(cur.fl[1]),
		.source_fifo_error(cur.fl[0]), .head_dword_byte_mask(cur.head),
		.tail_dword_byte_mask(cur.tail), .source_hint_present(cur.hint),
		.source_hint_type(cur.htype), .hint_steering_value(cur.steer), .request_valid,
		.request_ready, .request_data_bus, .request_last_beat, .request_sideband_bus,
		.aer_payload_error);
	cq_user_sink u_sink (.pclk, .presetn, .stall_mode, .request_valid, .request_ready,
		.request_last_beat, .request_sideband_bus, .dropped);

	// Clock, cycle ceiling and error report tally
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (aer_payload_error === 1'h1)
			aer_seen++;
		if (cycles == 5000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// Offer one source beat until it is taken
	task automatic send(input row_type r, input logic [255:0] data, input logic last);
		cur <= r;
		source_data <= data;
		source_last <= last;
		source_valid <= 1'h1;
		do @(posedge pclk); while (source_ready !== 1'h1);
		source_valid <= 1'h0;
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, source_valid, source_last, stall_mode} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		source_data = 256'h0;
		cur = '{default: '0};
		rows = '{
			'{8'h00, 6'h01, 4'hF, 4'h0, 1'h0, 2'h0, 8'h00, 8'h0F, 32'h0},
			'{8'h10, 6'h38, 4'h6, 4'h0, 1'h0, 2'h0, 8'h00, 8'h06, 32'h00060000},
			'{8'hF0, 6'h38, 4'hC, 4'h3, 1'h0, 2'h0, 8'h00, 8'h3C, 32'h3FFC0000},
			'{8'h30, 6'h3A, 4'h0, 4'h0, 1'h0, 2'h0, 8'h00, 8'hFF, 32'h00FF0000},
			'{8'h10, 6'h3C, 4'h0, 4'h0, 1'h0, 2'h0, 8'h00, 8'h00, 32'h0},
			'{8'h00, 6'h00, 4'hF, 4'h0, 1'h1, 2'h2, 8'hA5, 8'h0F, 32'h0},
			'{8'h03, 6'h38, 4'h3, 4'hE, 1'h0, 2'h0, 8'h00, 8'hE3, 32'h000000E3}};
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// Reset values and a refused address
		apb(1'h0, 12'h000, 32'h0);
		check("ctrl reset", 256'h6, {er, rd});
		apb(1'h0, 12'h008, 32'h0);
		check("error reset", 256'h0, rd);
		apb(1'h0, 12'h00C, 32'h0);
		check("unmapped", 256'h100000000, {er, rd});
		$display("Test registers done");
		// Row table at each data path width
		for (int w = 0; w < 3; w++) begin
			apb(1'h1, 12'h000, 32'h4 | 32'(w));
			ln = w == 0 ? 32'h000000FF : w == 1 ? 32'h0000FFFF : 32'hFFFFFFFF;
			for (int i = 0; i < 7; i++) begin
				for (int b = 0; b < 32; b++) begin
					d[8*b+:8] = 8'(b * 7 + i * 3 + 1);
					par[b] = ~^d[8*b+:8] & ln[b];
					dm[8*b+:8] = {8{ln[b]}};
				end
				send(rows[i], d, 1'h1);
				do @(negedge pclk); while (!(request_valid === 1'h1 && request_ready === 1'h1));
				xsb = {par, rows[i].steer, rows[i].htype, rows[i].hint, 2'h1, rows[i].xen & ln,
					rows[i].xmask};
				check("data", d & dm, request_data_bus);
				check("last", 256'h1, request_last_beat);
				check("sideband", xsb, request_sideband_bus);
				@(posedge pclk);
			end
			$display("Test width %0d done", w);
		end
		// Two-beat packet aborted on its last beat, receiver stalling
		stall_mode <= 1'h1;
		beat = rows[2];
		beat.fl = 6'h28;
		send(beat, d, 1'h0);
		@(posedge pclk);
		beat.fl = 6'h19;
		beat.pdw = 8'h0F;
		send(beat, ~d, 1'h1);
		do @(posedge pclk); while (dropped !== 8'h01);
		repeat (2) @(posedge pclk);
		check("dropped", 256'h1, dropped);
		check("error report", 256'h1, aer_seen);
		apb(1'h1, 12'h004, 32'hFFFFFFFF);
		apb(1'h0, 12'h004, 32'h0);
		check("abort count", 256'h1, rd[31:16]);
		check("packet count", 256'h16, rd[15:0]);
		apb(1'h0, 12'h008, 32'h0);
		check("sticky set", 256'h1, rd);
		apb(1'h1, 12'h008, 32'h1);
		apb(1'h0, 12'h008, 32'h0);
		check("sticky clear", 256'h0, rd);
		$display("Test abort done");
		// Aborted single beat with endpoint reporting off
		apb(1'h1, 12'h000, 32'h2);
		stall_mode <= 1'h0;
		beat.fl = 6'h39;
		beat.pdw = 8'h01;
		send(beat, d, 1'h1);
		do @(posedge pclk); while (dropped !== 8'h02);
		repeat (2) @(posedge pclk);
		check("dropped second", 256'h2, dropped);
		check("error report off", 256'h1, aer_seen);
		$display("Test endpoint off done");
		give_verdict();
	end
endmodule
